// file: core/pcr_pkg.sv
package pcr_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	// register offsets (byte addresses on the host port)
	localparam logic [7:0] OFS_MODULE_SETUP = 8'h04;
	localparam logic [7:0] OFS_OPTION_FLAGS = 8'h06;
	localparam logic [7:0] OFS_HOST_DRIVE = 8'h9A;
	localparam logic [7:0] OFS_PHY_DRIVE = 8'h9C;
	localparam logic [7:0] OFS_HOST_PULL_EN = 8'h9E;
	// module_setup_reg0 fields
	localparam int BIT_CONFIG = 15;
	localparam int BIT_CHAN_B = 9;
	localparam int BIT_CHAN_A = 8;
	localparam int BIT_SYNC_FILT = 6;
	localparam int BIT_NODE_SYNC = 5;
	// protocol_option_flags fields
	localparam int BIT_ALLOW_YELLOW_TO_GREEN = 10;
	localparam int BIT_ARL = 9;
	localparam int BIT_CSI = 8;
	localparam int BIT_EXT_CLK_SYNC_ENABLE = 6;
	localparam int BIT_DYNSEG = 5;
	localparam int BIT_SYMWIN = 4;
	localparam int BIT_MEDIA_TEST_ENABLE = 2;
	// writable masks
	localparam logic [15:0] MASK_SETUP_CFG = 16'h0340;
	localparam logic [15:0] MASK_OPTIONS = 16'h0774;
	localparam logic [15:0] MASK_HOST_DRIVE = 16'h003F;
	localparam logic [15:0] MASK_PHY_DRIVE = 16'h000F;
	localparam logic [15:0] MASK_HOST_PULL = 16'hFFFF;
	// reset values
	localparam logic [15:0] RST_SETUP = 16'h8000;
	localparam logic [15:0] RST_OPTIONS = 16'h0000;
	localparam logic [15:0] RST_DRIVE = 16'h0000;
	localparam logic [15:0] RST_PULL = 16'h0000;
endpackage : pcr_pkg

// file: core/pcr_regs.sv
// Function
// - set node_in_sync in idle before normal
// - clear node_in_sync in idle before yellow/red
// - filter enabled: accept-pass and not rejected
// - filter disabled: every sync frame used
// - chan_a_enable, writable only in config
// - chan_b_enable, writable only in config
// - writing config 1 enters config, aborts
// - writing config 0 resumes normal operation
// - after reset config state, bit reads 1
// - media_test_enable drives media access test
// - guard_symwin_open sets symbol window expectation
// - guard_dynseg_open sets dynamic segment expectation
// - ext_clk_sync_enable gates external clock sync
// - coldstart inhibit blocks coldstarting
// - allow_red_level chooses red or config
// - allow_yellow_to_green gates yellow to green
// - drive bit 1 partial, 0 full
// - pull enable bit 1 enables resistor
// - setting config with others changes only config
`timescale 1ns/10ps
`default_nettype none
module pcr_regs
	import pcr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic [DATA_W-1:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [DATA_W-1:0] bus_rdata,
	input wire logic eng_enter_normal,
	input wire logic eng_leave_sync,
	input wire logic eng_sync_frame,
	input wire logic eng_accept_pass,
	input wire logic eng_reject_hit,
	output logic config_state,
	output logic abort_pulse,
	output logic sync_frame_used,
	output logic node_in_sync,
	output logic chan_a_enable,
	output logic chan_b_enable,
	output logic media_test_enable,
	output logic guard_symwin_open,
	output logic guard_dynseg_open,
	output logic ext_clk_sync_enable,
	output logic coldstart_inhibit,
	output logic allow_red_level,
	output logic allow_yellow_to_green,
	output logic [5:0] host_drive_partial,
	output logic [3:0] phy_drive_partial,
	output logic [15:0] host_pull_enable
);
	logic config_q;
	logic config_d;
	logic sync_q;
	logic sync_d;
	logic [15:0] setup_q;
	logic [15:0] setup_d;
	logic [15:0] opt_q;
	logic [15:0] opt_d;
	logic [15:0] hdrv_q;
	logic [15:0] pdrv_q;
	logic [15:0] pull_q;
	logic abort_q;
	logic used_q;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wr,
		input logic [15:0] mask);
		merge = (old & ~mask) | (wr & mask);
	endfunction : merge

	wire logic wr_setup = bus_wr && (bus_addr == OFS_MODULE_SETUP);
	wire logic wr_opt = bus_wr && (bus_addr == OFS_OPTION_FLAGS);
	wire logic wr_hdrv = bus_wr && (bus_addr == OFS_HOST_DRIVE);
	wire logic wr_pdrv = bus_wr && (bus_addr == OFS_PHY_DRIVE);
	wire logic wr_pull = bus_wr && (bus_addr == OFS_HOST_PULL_EN);
	wire logic new_config = bus_wdata[BIT_CONFIG];
	// setting config alone wins; other fields only accepted while config held and not being set
	wire logic set_cfg = wr_setup && new_config && !config_q;
	wire logic fields_ok = wr_setup && config_q && !set_cfg;

	assign config_d = wr_setup ? new_config : config_q;
	assign setup_d = fields_ok ? merge(setup_q, bus_wdata, MASK_SETUP_CFG) : setup_q;
	assign opt_d = (wr_opt && config_q) ? merge(opt_q, bus_wdata, MASK_OPTIONS) : opt_q;
	// entering config drops sync; clear wins over set since it is the fault path
	assign sync_d = (eng_leave_sync || config_d) ? 1'b0
		: (eng_enter_normal ? 1'b1 : sync_q);

	wire logic frame_ok = eng_sync_frame && (!setup_q[BIT_SYNC_FILT]
		|| (eng_accept_pass && !eng_reject_hit));

	wire logic [15:0] setup_view = {config_q, setup_q[14:6], sync_q, setup_q[4:0]};
	assign rdata_d = !bus_rd ? 16'h0000
		: (bus_addr == OFS_MODULE_SETUP) ? setup_view
		: (bus_addr == OFS_OPTION_FLAGS) ? opt_q
		: (bus_addr == OFS_HOST_DRIVE) ? hdrv_q
		: (bus_addr == OFS_PHY_DRIVE) ? pdrv_q
		: (bus_addr == OFS_HOST_PULL_EN) ? pull_q
		: 16'h0000;

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			config_q <= 1'b1;
			setup_q <= RST_SETUP & MASK_SETUP_CFG;
			opt_q <= RST_OPTIONS;
			hdrv_q <= RST_DRIVE;
			pdrv_q <= RST_DRIVE;
			pull_q <= RST_PULL;
			sync_q <= 1'b0;
			abort_q <= 1'b0;
			used_q <= 1'b0;
			rdata_q <= 16'h0000;
		end
		else
		begin
			config_q <= config_d;
			setup_q <= setup_d;
			opt_q <= opt_d;
			if (wr_hdrv)
				hdrv_q <= bus_wdata & MASK_HOST_DRIVE;
			if (wr_pdrv)
				pdrv_q <= bus_wdata & MASK_PHY_DRIVE;
			if (wr_pull)
				pull_q <= bus_wdata & MASK_HOST_PULL;
			sync_q <= sync_d;
			abort_q <= set_cfg;
			used_q <= frame_ok;
			rdata_q <= rdata_d;
		end
	end

	// registered copies keep every output straight from a flip-flop
	assign bus_rdata = rdata_q;
	assign config_state = config_q;
	assign abort_pulse = abort_q;
	assign sync_frame_used = used_q;
	assign node_in_sync = sync_q;
	assign chan_a_enable = setup_q[BIT_CHAN_A];
	assign chan_b_enable = setup_q[BIT_CHAN_B];
	assign media_test_enable = opt_q[BIT_MEDIA_TEST_ENABLE];
	assign guard_symwin_open = opt_q[BIT_SYMWIN];
	assign guard_dynseg_open = opt_q[BIT_DYNSEG];
	assign ext_clk_sync_enable = opt_q[BIT_EXT_CLK_SYNC_ENABLE];
	assign coldstart_inhibit = opt_q[BIT_CSI];
	assign allow_red_level = opt_q[BIT_ARL];
	assign allow_yellow_to_green = opt_q[BIT_ALLOW_YELLOW_TO_GREEN];
	assign host_drive_partial = hdrv_q[5:0];
	assign phy_drive_partial = pdrv_q[3:0];
	assign host_pull_enable = pull_q;
endmodule : pcr_regs
`default_nettype wire

// file: sim/pcr_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module pcr_regs_checker
	import pcr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic [DATA_W-1:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic eng_enter_normal,
	input wire logic eng_leave_sync,
	input wire logic config_state,
	input wire logic abort_pulse,
	input wire logic node_in_sync,
	input wire logic chan_a_enable,
	input wire logic chan_b_enable
);
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire logic sw = bus_wr && bus_addr == OFS_MODULE_SETUP;
	wire logic go = sw && bus_wdata[BIT_CONFIG];
	sequence s_abort; abort_pulse ##1 !abort_pulse; endsequence
	property p_rst; $fell(reset) |-> config_state; endproperty
	a_rst: assert property (p_rst) else $error("no config after reset");
	property p_cfg; go |=> config_state; endproperty
	a_cfg: assert property (p_cfg) else $error("config not entered");
	property p_abort; go && !config_state |=> s_abort; endproperty
	a_abort: assert property (p_abort) else $error("abort pulse wrong");
	property p_run; sw && !bus_wdata[BIT_CONFIG] |=> !config_state; endproperty
	a_run: assert property (p_run) else $error("config not left");
	property p_hold; config_state && !sw |=> config_state; endproperty
	a_hold: assert property (p_hold) else $error("config lost");
	property p_sync; eng_enter_normal && !eng_leave_sync && !config_state && !sw |=> node_in_sync; endproperty
	a_sync: assert property (p_sync) else $error("sync not set");
	property p_unsync; eng_leave_sync |=> !node_in_sync; endproperty
	a_unsync: assert property (p_unsync) else $error("sync not cleared");
	// channel enables frozen outside config, a config-setting write included
	property p_lock; !config_state |=> $stable({chan_a_enable, chan_b_enable}); endproperty
	a_lock: assert property (p_lock) else $error("channel changed");
endmodule : pcr_regs_checker
bind pcr_regs pcr_regs_checker u_pcr_regs_checker (.*);
`default_nettype wire

// file: sim/pcr_engine_model.sv
`timescale 1ns/10ps
`default_nettype none
module pcr_engine_model (
	input wire logic ref_clk,
	input wire logic run,
	output logic [4:0] ev
);
	logic [15:0] s = 16'hACE1;
	initial ev = 5'h00;
	// rare state events, frequent frames
	always @(posedge ref_clk)
	begin
		s <= {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
		ev <= run ? {s[3:0] == 4'h0, s[7:4] == 4'h0, s[10:8]} : 5'h00;
	end
endmodule : pcr_engine_model
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import pcr_pkg::*;
	logic ref_clk = 1'b0, reset = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, run = 1'b0;
	logic [7:0] bus_addr = 8'h00;
	logic [15:0] bus_wdata = 16'h0000, rnd = 16'h001B;
	logic [15:0] v [4];
	logic [7:0] ad [4] = '{OFS_OPTION_FLAGS, OFS_HOST_DRIVE, OFS_PHY_DRIVE, OFS_HOST_PULL_EN};
	logic [15:0] mk [4] = '{MASK_OPTIONS, MASK_HOST_DRIVE, MASK_PHY_DRIVE, MASK_HOST_PULL};
	wire [4:0] ev;
	wire [15:0] bus_rdata, host_pull_enable;
	wire [5:0] host_drive_partial;
	wire [3:0] phy_drive_partial;
	wire config_state, abort_pulse, sync_frame_used, node_in_sync, chan_a_enable, chan_b_enable, media_test_enable;
	wire guard_symwin_open, guard_dynseg_open, ext_clk_sync_enable, coldstart_inhibit, allow_red_level;
	wire allow_yellow_to_green;
	wire eng_enter_normal = ev[4], eng_leave_sync = ev[3], eng_sync_frame = ev[2];
	wire eng_accept_pass = ev[1], eng_reject_hit = ev[0];
	int miscompares = 0, check_count = 0;
	always #5 ref_clk = ~ref_clk;
	pcr_regs u_pcr_regs (.*);
	pcr_engine_model u_pcr_engine_model (.ref_clk(ref_clk), .run(run), .ev(ev));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		#1 chk(bus_rdata, exp);
	endtask : rd
	// engine traffic; expectation lags the sampled events by one cycle
	task automatic eng_run(input logic filt);
		logic used, ns;
		used = 1'b0;
		ns = 1'b0;
		run <= 1'b1;
		repeat (60)
		begin
			@(posedge ref_clk);
			#1 chk(sync_frame_used, used);
			chk(node_in_sync, ns);
			used = eng_sync_frame && (!filt || (eng_accept_pass && !eng_reject_hit));
			ns = eng_leave_sync ? 1'b0 : (eng_enter_normal ? 1'b1 : ns);
		end
		run <= 1'b0;
	endtask : eng_run
	task automatic report_and_stop;
		if (miscompares == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		rd(OFS_MODULE_SETUP, RST_SETUP);
		rd(8'h10, 16'h0000);
		wr(OFS_MODULE_SETUP, 16'h8360);
		rd(OFS_MODULE_SETUP, 16'h8340);
		for (int i = 0; i < 4; i++)
		begin
			rd(ad[i], 16'h0000);
			rnd = lfsr(rnd);
			v[i] = rnd & mk[i];
			wr(ad[i], v[i]);
			rd(ad[i], v[i]);
		end
		chk({allow_yellow_to_green, allow_red_level, coldstart_inhibit, 1'b0, ext_clk_sync_enable,
			guard_dynseg_open, guard_symwin_open, 1'b0, media_test_enable, 2'b00}, v[0]);
		chk({host_drive_partial, phy_drive_partial}, {v[1][5:0], v[2][3:0]});
		chk(host_pull_enable, v[3]);
		wr(OFS_MODULE_SETUP, 16'h0300);
		#1 chk({config_state, chan_b_enable, chan_a_enable}, 3'b011);
		eng_run(1'b0);
		wr(OFS_MODULE_SETUP, 16'h0000);
		#1 chk({config_state, chan_b_enable, chan_a_enable}, 3'b011);
		wr(OFS_OPTION_FLAGS, ~v[0] & MASK_OPTIONS);
		wr(OFS_MODULE_SETUP, 16'h8040);
		rd(OFS_MODULE_SETUP, 16'h8300);
		rd(OFS_OPTION_FLAGS, v[0]);
		wr(OFS_MODULE_SETUP, 16'h0240);
		rd(OFS_MODULE_SETUP, 16'h0240);
		eng_run(1'b1);
		report_and_stop;
	end
endmodule : testbench
`default_nettype wire
